// ==== rtl/pio_timer.sv ====
/*
  parallel port and interval timer with axi4-lite register access.
  assumes the peripheral pins are asynchronous and the timer reference
  arrives as a slow level on a pin; single core clock.
*/
module pio_timer
(
  input  wire logic        core_clk,   // 50 mhz clock
  input  wire logic        rstn,       // async reset, low
  input  wire logic [7:0]  s_awaddr,   // write address
  input  wire logic        s_awvalid,  // write address valid
  output logic             s_awready,  // write address ready
  input  wire logic [31:0] s_wdata,    // write data
  input  wire logic [3:0]  s_wstrb,    // byte strobes
  input  wire logic        s_wvalid,   // write data valid
  output logic             s_wready,   // write data ready
  output logic [1:0]       s_bresp,    // write response
  output logic             s_bvalid,   // write response valid
  input  wire logic        s_bready,   // write response ready
  input  wire logic [7:0]  s_araddr,   // read address
  input  wire logic        s_arvalid,  // read address valid
  output logic             s_arready,  // read address ready
  output logic [31:0]      s_rdata,    // read data
  output logic [1:0]       s_rresp,    // read response
  output logic             s_rvalid,   // read data valid
  input  wire logic        s_rready,   // read data ready
  input  wire logic [7:0]  p1_in,      // port 1 pins in
  output logic      [7:0]  p1_out,     // port 1 pins out
  output logic      [7:0]  p1_oe,      // port 1 drive enables
  input  wire logic [7:0]  p2_in,      // port 2 pins in
  output logic      [7:0]  p2_out,     // port 2 pins out
  output logic      [7:0]  p2_oe,      // port 2 drive enables
  input  wire logic [2:0]  p3_in,      // port 3 pins in
  output logic      [2:0]  p3_out,     // port 3 pins out
  output logic      [2:0]  p3_oe,      // port 3 drive enables
  input  wire logic [2:0]  p4_in,      // port 4 pins in
  output logic      [2:0]  p4_out,     // port 4 pins out
  output logic      [2:0]  p4_oe,      // port 4 drive enables
  input  wire logic        tmr_ref,    // timer reference clock pin
  output logic             tmr_out,    // timer output
  output logic             irq         // level interrupt
);
  // pin synchronisers
  logic [21:0] sy1, sy2;
  logic        ref1, ref2, ref_d;
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      sy1   <= '1;
      sy2   <= '1;
      ref1  <= 1'b0;
      ref2  <= 1'b0;
      ref_d <= 1'b0;
    end
    else
    begin
      sy1   <= {p4_in, p3_in, p2_in, p1_in};
      sy2   <= sy1;
      ref1  <= tmr_ref;
      ref2  <= ref1;
      ref_d <= ref2;
    end
  wire [7:0] s1 = sy2[7:0];
  wire [7:0] s2 = sy2[15:8];
  wire [2:0] s3 = sy2[18:16];
  wire [2:0] s4 = sy2[21:19];
  wire tick = ref2 & ~ref_d;

  // registers
  logic [pio_timer_pkg::CTRL_W-1:0] ctrl;
  logic [7:0]  p3_latch, p4_latch;
  logic [13:0] tlen;
  logic [3:0]  stat, mask;

  wire [1:0] m1 = ctrl[pio_timer_pkg::CF_P1_LO +: 2];
  wire [1:0] m2 = ctrl[pio_timer_pkg::CF_P2_LO +: 2];
  wire [1:0] m3 = ctrl[pio_timer_pkg::CF_P3_LO +: 2];
  wire [1:0] m4 = ctrl[pio_timer_pkg::CF_P4_LO +: 2];
  wire [1:0] tfn = ctrl[pio_timer_pkg::CF_TF_LO +: 2];
  wire ctl3 = m1 == pio_timer_pkg::PM_IN_STB || m1 == pio_timer_pkg::PM_OUT_STB;
  wire ctl4 = m2 == pio_timer_pkg::PM_IN_STB || m2 == pio_timer_pkg::PM_OUT_STB;

  // axi write channel: both halves held until taken together
  logic       aw_ok, w_ok;
  logic [7:0] aw_a;
  logic [31:0] w_d;
  logic [3:0] w_s;
  wire do_wr = aw_ok & w_ok & ~s_bvalid;
  wire wen   = do_wr & w_s[0];
  wire wr_ctrl = wen && aw_a == pio_timer_pkg::OFF_CTRL;
  wire wr_p1   = wen && aw_a == pio_timer_pkg::OFF_P1;
  wire wr_p2   = wen && aw_a == pio_timer_pkg::OFF_P2;
  wire wr_p3   = wen && aw_a == pio_timer_pkg::OFF_P3;
  wire wr_p4   = wen && aw_a == pio_timer_pkg::OFF_P4;
  wire wr_tlen = do_wr && aw_a == pio_timer_pkg::OFF_TLEN;
  wire wr_stat = wen && aw_a == pio_timer_pkg::OFF_STAT;
  wire wr_mask = wen && aw_a == pio_timer_pkg::OFF_MASK;
  wire wr_hit  = aw_a inside {pio_timer_pkg::OFF_CTRL, pio_timer_pkg::OFF_P1, pio_timer_pkg::OFF_P2,
                 pio_timer_pkg::OFF_P3, pio_timer_pkg::OFF_P4, pio_timer_pkg::OFF_TLEN,
                 pio_timer_pkg::OFF_TCNT, pio_timer_pkg::OFF_STAT, pio_timer_pkg::OFF_MASK};
  wire start   = wr_ctrl & w_d[pio_timer_pkg::CF_START];
  wire stop    = wr_ctrl & w_d[pio_timer_pkg::CF_STOP];

  // read channel
  logic [7:0] ar_a;
  logic       ar_ok;
  wire do_rd = ar_ok & ~s_rvalid;
  wire rd_p1 = do_rd && ar_a == pio_timer_pkg::OFF_P1;
  wire rd_p2 = do_rd && ar_a == pio_timer_pkg::OFF_P2;

  // ports 1 and 2
  wire [7:0] o1, o2, i1, i2;
  wire bf1, bf2, it1, it2, ev1, ev2;
  hs_port u_p1 (.core_clk(core_clk), .rstn(rstn), .mode(m1), .pin_in(s1), .stb_in(s3[pio_timer_pkg::H_STB]),
    .wr(wr_p1), .rd(rd_p1), .wdata(w_d[7:0]), .out_latch(o1), .in_latch(i1), .buf_full(bf1),
    .intr(it1), .ev(ev1));
  hs_port u_p2 (.core_clk(core_clk), .rstn(rstn), .mode(m2), .pin_in(s2), .stb_in(s4[pio_timer_pkg::H_STB]),
    .wr(wr_p2), .rd(rd_p2), .wdata(w_d[7:0]), .out_latch(o2), .in_latch(i2), .buf_full(bf2),
    .intr(it2), .ev(ev2));

  wire out1 = m1 == pio_timer_pkg::PM_OUT || m1 == pio_timer_pkg::PM_OUT_STB;
  wire out2 = m2 == pio_timer_pkg::PM_OUT || m2 == pio_timer_pkg::PM_OUT_STB;
  wire out3 = m3 == pio_timer_pkg::SM_OUT;
  wire out4 = m4 == pio_timer_pkg::SM_OUT;
  // control port: intr and buffer full driven, strobe line received
  wire [2:0] hs3 = {1'b0, bf1, it1};
  wire [2:0] hs4 = {1'b0, bf2, it2};
  wire [2:0] ctl_oe = 3'h3;

  // timer
  logic [13:0] tcnt;
  logic        trun, tlo;
  wire [13:0] half = {1'b0, tlen[13:1]};
  wire        tc   = trun & tick & (tcnt <= 14'h0001);
  wire [13:0] tdec = tcnt - 14'h0001;
  wire        mid  = tdec <= half;

  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      tcnt <= 14'h0000;
      trun <= 1'b0;
      tlo  <= 1'b0;
    end
    else if (start)
    begin
      tcnt <= tlen;
      trun <= 1'b1;
      tlo  <= 1'b0;
    end
    else if (stop)
      trun <= 1'b0;
    else if (trun && tick)
    begin
      if (tc)
      begin
        tcnt <= tlen;
        case (tfn)
          pio_timer_pkg::TF_PULSE:
          begin
            trun <= 1'b0;
            tlo  <= 1'b0;
          end
          pio_timer_pkg::TF_SQUARE: tlo <= 1'b0;
          pio_timer_pkg::TF_RATE:   tlo <= 1'b1;
          pio_timer_pkg::TF_STROBE:
          begin
            trun <= 1'b0;
            tlo  <= 1'b1;
          end
          default:                  tlo <= 1'b0;
        endcase
      end
      else
      begin
        tcnt <= tdec;
        case (tfn)
          pio_timer_pkg::TF_PULSE:  tlo <= mid;
          pio_timer_pkg::TF_SQUARE: tlo <= mid;
          default:                  tlo <= 1'b0;
        endcase
      end
    end
    else if (tick)
      tlo <= 1'b0; // strobe low lasts one reference period

  // axi slave and register file
  wire [31:0] rmux =
    ar_a == pio_timer_pkg::OFF_CTRL ? {20'h0, ctrl} :
    ar_a == pio_timer_pkg::OFF_P1   ? {24'h0, out1 ? o1 : i1} :
    ar_a == pio_timer_pkg::OFF_P2   ? {24'h0, out2 ? o2 : i2} :
    ar_a == pio_timer_pkg::OFF_P3   ? {29'h0, ctl3 ? {s3[2], bf1, it1} : out3 ? p3_latch[2:0] : s3} :
    ar_a == pio_timer_pkg::OFF_P4   ? {29'h0, ctl4 ? {s4[2], bf2, it2} : out4 ? p4_latch[2:0] : s4} :
    ar_a == pio_timer_pkg::OFF_TLEN ? {18'h0, tlen} :
    ar_a == pio_timer_pkg::OFF_TCNT ? {17'h0, trun, tcnt} :
    ar_a == pio_timer_pkg::OFF_STAT ? {28'h0, stat} :
    ar_a == pio_timer_pkg::OFF_MASK ? {28'h0, mask} : 32'h0000_0000;
  wire rd_hit = ar_a inside {pio_timer_pkg::OFF_CTRL, pio_timer_pkg::OFF_P1, pio_timer_pkg::OFF_P2,
                pio_timer_pkg::OFF_P3, pio_timer_pkg::OFF_P4, pio_timer_pkg::OFF_TLEN,
                pio_timer_pkg::OFF_TCNT, pio_timer_pkg::OFF_STAT, pio_timer_pkg::OFF_MASK};
  wire [3:0] evs = {ev1 & ev2, ev2, ev1, tc};

  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      aw_ok    <= 1'b0;
      w_ok     <= 1'b0;
      aw_a     <= 8'h00;
      w_d      <= 32'h0000_0000;
      w_s      <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp  <= pio_timer_pkg::RESP_OKAY;
      ar_ok    <= 1'b0;
      ar_a     <= 8'h00;
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= pio_timer_pkg::RESP_OKAY;
      ctrl     <= '0;
      p3_latch <= 8'h00;
      p4_latch <= 8'h00;
      tlen     <= 14'h0000;
      stat     <= 4'h0;
      mask     <= 4'h0;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_ok <= 1'b1;
        aw_a  <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_ok <= 1'b1;
        w_d  <= s_wdata;
        w_s  <= s_wstrb;
      end
      if (do_wr)
      begin
        aw_ok    <= 1'b0;
        w_ok     <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_hit ? pio_timer_pkg::RESP_OKAY : pio_timer_pkg::RESP_SLVERR;
      end
      else if (s_bready)
        s_bvalid <= 1'b0;
      if (s_arvalid && s_arready)
      begin
        ar_ok <= 1'b1;
        ar_a  <= s_araddr;
      end
      if (do_rd)
      begin
        ar_ok    <= 1'b0;
        s_rvalid <= 1'b1;
        s_rdata  <= rmux;
        s_rresp <= rd_hit ? pio_timer_pkg::RESP_OKAY : pio_timer_pkg::RESP_SLVERR;
      end
      else if (s_rready)
        s_rvalid <= 1'b0;
      if (wr_ctrl) ctrl <= {2'b00, w_d[9:0]};
      if (wr_p3) p3_latch <= w_d[7:0];
      if (wr_p4) p4_latch <= w_d[7:0];
      if (wr_tlen && w_s[0]) tlen[7:0] <= w_d[7:0];
      if (wr_tlen && w_s[1]) tlen[13:8] <= w_d[13:8];
      if (wr_mask) mask <= w_d[3:0];
      // set wins over write-one-to-clear
      stat <= (stat & ~(wr_stat ? w_d[3:0] : 4'h0)) | evs;
    end

  assign s_awready = ~aw_ok;
  assign s_wready  = ~w_ok;
  assign s_arready = ~ar_ok;

  // pin drivers, all from flops
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      p1_out  <= 8'h00;
      p1_oe   <= 8'h00;
      p2_out  <= 8'h00;
      p2_oe   <= 8'h00;
      p3_out  <= 3'h0;
      p3_oe   <= 3'h0;
      p4_out  <= 3'h0;
      p4_oe   <= 3'h0;
      tmr_out <= 1'b1;
      irq     <= 1'b0;
    end
    else
    begin
      p1_out <= o1;
      p1_oe  <= {8{out1}};
      p2_out <= o2;
      p2_oe  <= {8{out2}};
      p3_out <= ctl3 ? hs3 : p3_latch[2:0];
      p3_oe  <= ctl3 ? ctl_oe : {3{out3}};
      p4_out <= ctl4 ? hs4 : p4_latch[2:0];
      p4_oe  <= ctl4 ? ctl_oe : {3{out4}};
      tmr_out <= ~tlo;
      irq <= |(stat & mask);
    end
endmodule

// ==== rtl/pio_timer_pkg.sv ====
/*
  constants for the parallel port and interval timer block: register map,
  field positions, port modes, timer functions.
  assumes a 32-bit axi4-lite master and a 50 mhz core clock.
*/
package pio_timer_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_P1     = 8'h04;
  localparam logic [7:0] OFF_P2     = 8'h08;
  localparam logic [7:0] OFF_P3     = 8'h0c;
  localparam logic [7:0] OFF_P4     = 8'h10;
  localparam logic [7:0] OFF_TLEN   = 8'h14;
  localparam logic [7:0] OFF_TCNT   = 8'h18;
  localparam logic [7:0] OFF_STAT   = 8'h1c;
  localparam logic [7:0] OFF_MASK   = 8'h20;
  localparam int P_W  = 8;
  localparam int S_W  = 3;
  localparam int T_W  = 14;
  localparam int EV_W = 4;
  // ctrl field layout
  localparam int CF_P1_LO  = 0;
  localparam int CF_P2_LO  = 2;
  localparam int CF_P3_LO  = 4;
  localparam int CF_P4_LO  = 6;
  localparam int CF_TF_LO  = 8;
  localparam int CF_START  = 10;
  localparam int CF_STOP   = 11;
  localparam int CTRL_W    = 12;
  // event bits
  localparam int EV_TC  = 0;
  localparam int EV_P1  = 1;
  localparam int EV_P2  = 2;
  localparam int EV_P12 = 3;
  // port 1/2 modes
  localparam logic [1:0] PM_IN     = 2'h0;
  localparam logic [1:0] PM_IN_STB = 2'h1;
  localparam logic [1:0] PM_OUT    = 2'h2;
  localparam logic [1:0] PM_OUT_STB= 2'h3;
  // port 3/4 modes (control when partner strobed)
  localparam logic [1:0] SM_IN  = 2'h0;
  localparam logic [1:0] SM_OUT = 2'h2;
  // timer functions
  localparam logic [1:0] TF_PULSE  = 2'h0;
  localparam logic [1:0] TF_SQUARE = 2'h1;
  localparam logic [1:0] TF_RATE   = 2'h2;
  localparam logic [1:0] TF_STROBE = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // control line positions on port 3/4: 0 = intr, 1 = buffer full, 2 = strobe in
  localparam int H_INTR = 0;
  localparam int H_BF   = 1;
  localparam int H_STB  = 2;
endpackage

// ==== rtl/hs_port.sv ====
/*
  one 8-bit port with its optional 3-line handshake partner.
  assumes pin inputs already synchronised by the caller.
*/
module hs_port
(
  input  wire logic       core_clk,   // clock
  input  wire logic       rstn,       // async reset, low
  input  wire logic [1:0] mode,       // port mode
  input  wire logic [7:0] pin_in,     // synchronised pins
  input  wire logic       stb_in,     // synchronised strobe, active low
  input  wire logic       wr,         // software wrote the output latch
  input  wire logic       rd,         // software read the input latch
  input  wire logic [7:0] wdata,      // write data
  output logic      [7:0] out_latch,  // output latch
  output logic      [7:0] in_latch,   // input view
  output logic            buf_full,   // handshake buffer full
  output logic            intr,       // handshake request
  output logic            ev          // one-cycle event
);
  logic       stb_d;
  logic [7:0] cap;
  wire stb_rise = stb_in & ~stb_d;
  wire strobed  = mode == pio_timer_pkg::PM_IN_STB || mode == pio_timer_pkg::PM_OUT_STB;
  wire is_in_s  = mode == pio_timer_pkg::PM_IN_STB;
  wire is_out_s = mode == pio_timer_pkg::PM_OUT_STB;

  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      stb_d     <= 1'b1;
      cap       <= 8'h00;
      out_latch <= 8'h00;
      buf_full  <= 1'b0;
      intr      <= 1'b0;
    end
    else
    begin
      stb_d <= stb_in;
      if (wr)
        out_latch <= wdata;
      if (is_in_s && !stb_in)
        cap <= pin_in;
      // strobe event wins over a same-cycle software access
      if (strobed && stb_rise)
      begin
        buf_full <= is_in_s;
        intr     <= 1'b1;
      end
      else if ((is_in_s && rd) || (is_out_s && wr))
      begin
        buf_full <= is_out_s;
        intr     <= 1'b0;
      end
      else if (!strobed)
      begin
        buf_full <= 1'b0;
        intr     <= 1'b0;
      end
    end

  assign in_latch = is_in_s ? cap : pin_in;
  assign ev       = strobed & stb_rise;
endmodule

// ==== tb/pio_timer_properties.sv ====
/*
  port-level checks for pio_timer, bound into every instance.
  assumes the single core clock and active-low asynchronous rstn.
*/
module pio_timer_props
(
  input wire logic       core_clk,  // clock
  input wire logic       rstn,      // reset, low
  input wire logic       s_awvalid, // aw valid
  input wire logic       s_awready, // aw ready
  input wire logic       s_wvalid,  // w valid
  input wire logic       s_wready,  // w ready
  input wire logic       s_bvalid,  // b valid
  input wire logic       s_bready,  // b ready
  input wire logic       s_arvalid, // ar valid
  input wire logic       s_arready, // ar ready
  input wire logic       s_rvalid,  // r valid
  input wire logic       s_rready,  // r ready
  input wire logic [7:0] p1_oe,     // port 1 enables
  input wire logic [7:0] p2_oe,     // port 2 enables
  input wire logic [2:0] p3_oe,     // port 3 enables
  input wire logic [2:0] p4_oe,     // port 4 enables
  input wire logic       tmr_out    // timer output
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence s_rd_taken;
    s_arvalid && s_arready;
  endsequence

  property p_b_ans; s_wr_taken |-> ##[1:2] s_bvalid; endproperty
  a_b_ans: assert property (p_b_ans) else $error("write answer late");
  property p_b_keep; $fell(s_bvalid) |-> $past(s_bready); endproperty
  a_b_keep: assert property (p_b_keep) else $error("write answer dropped");
  // address flop, then the answer register: two edges
  property p_r_ans; s_rd_taken |-> ##2 s_rvalid; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_r_keep; $fell(s_rvalid) |-> $past(s_rready); endproperty
  a_r_keep: assert property (p_r_keep) else $error("read answer dropped");
  // whole port turns round at once: lines are unidirectional per port
  property p_p1_dir; p1_oe == 8'h00 || p1_oe == 8'hff; endproperty
  a_p1_dir: assert property (p_p1_dir) else $error("port 1 mixed drive");
  property p_p2_dir; p2_oe == 8'h00 || p2_oe == 8'hff; endproperty
  a_p2_dir: assert property (p_p2_dir) else $error("port 2 mixed drive");
  // control use: two lines out, strobe line in
  property p_p3_ctl; p3_oe inside {3'h0, 3'h3, 3'h7}; endproperty
  a_p3_ctl: assert property (p_p3_ctl) else $error("port 3 bad drive");
  property p_p4_ctl; p4_oe inside {3'h0, 3'h3, 3'h7}; endproperty
  a_p4_ctl: assert property (p_p4_ctl) else $error("port 4 bad drive");
  property p_tmr_idle; $rose(rstn) |-> tmr_out; endproperty
  a_tmr_idle: assert property (p_tmr_idle) else $error("timer output low at reset");
endmodule

bind pio_timer pio_timer_props pio_timer_props_inst (.core_clk, .rstn, .s_awvalid, .s_awready, .s_wvalid,
  .s_wready, .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rvalid, .s_rready, .p1_oe, .p2_oe, .p3_oe,
  .p4_oe, .tmr_out);

// ==== tb/periph_model.sv ====
/*
  peripheral side of the pins: line levels and the timer reference.
  assumes a design enable wins over the peripheral's own level.
*/
module periph_model
#(
  parameter int HALF_NS = 80 // reference half period
)
(
  input  wire logic       ref_run, // reference runs
  input  wire logic       stb_n,   // port 1 strobe, low
  input  wire logic [7:0] p1_out,  // port 1 drive
  input  wire logic [7:0] p1_oe,   // port 1 enables
  input  wire logic [7:0] p2_out,  // port 2 drive
  input  wire logic [7:0] p2_oe,   // port 2 enables
  input  wire logic [2:0] p3_out,  // port 3 drive
  input  wire logic [2:0] p3_oe,   // port 3 enables
  input  wire logic [2:0] p4_out,  // port 4 drive
  input  wire logic [2:0] p4_oe,   // port 4 enables
  output logic      [7:0] p1_in,   // port 1 level
  output logic      [7:0] p2_in,   // port 2 level
  output logic      [2:0] p3_in,   // port 3 level
  output logic      [2:0] p4_in,   // port 4 level
  output logic            tmr_ref  // timer reference
);
  timeunit 1ns;
  timeprecision 1ps;
  assign p1_in = (p1_oe & p1_out) | (~p1_oe & 8'h81);
  assign p2_in = (p2_oe & p2_out) | (~p2_oe & 8'h3c);
  assign p3_in = (p3_oe & p3_out) | (~p3_oe & {stb_n, 2'b01});
  assign p4_in = (p4_oe & p4_out) | (~p4_oe & 3'h6);
  // stands still when gated off, no stray ticks
  initial tmr_ref = 1'b0;
  always #(HALF_NS) tmr_ref = ref_run ? ~tmr_ref : 1'b0;
endmodule

// ==== tb/parallel_port_and_interval_timer_bench.sv ====
/*
  self-checking bench for pio_timer: axi4-lite tasks, ports, handshake,
  interrupt and timer runs. assumes periph_model on the pins, checker bound.
*/
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) \
  begin miscompares++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module parallel_port_and_interval_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rstn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready, tmr_ref, tmr_out, irq, ref_run, stb_n, mon, prev;
  logic [7:0]  s_awaddr, s_araddr, p1_in, p1_out, p1_oe, p2_in, p2_out, p2_oe;
  logic [2:0]  p3_in, p3_out, p3_oe, p4_in, p4_out, p4_oe;
  logic [31:0] s_wdata, s_rdata, v, t, w;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, rs;
  int          miscompares, n_checks, falls, lows;
  int          exp_falls [4] = '{1, 2, 2, 1};

  pio_timer pio_timer_inst (.core_clk, .rstn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .p1_in, .p1_out, .p1_oe, .p2_in, .p2_out, .p2_oe, .p3_in, .p3_out, .p3_oe, .p4_in, .p4_out,
    .p4_oe, .tmr_ref, .tmr_out, .irq);
  periph_model periph_model_inst (.ref_run, .stb_n, .p1_out, .p1_oe, .p2_out, .p2_oe, .p3_out, .p3_oe,
    .p4_out, .p4_oe, .p1_in, .p2_in, .p3_in, .p4_in, .tmr_ref);

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    if (mon && prev && !tmr_out) falls++;
    if (mon && !tmr_out) lows++;
    prev <= tmr_out;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic tmo;
    miscompares++;
    $display("MISMATCH bus wait exp answer got none");
    report_and_stop();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge core_clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge core_clk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) break;
    end
    if (n == 100) tmo();
    s_bready <= 1'b0;
    `CHK("bresp", er, s_bresp)
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge core_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge core_clk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) break;
    end
    if (n == 100) tmo();
    s_rready <= 1'b0;
    d = s_rdata;
    rs = s_rresp;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a, w);
    `CHK("rdata", e, w)
    `CHK("rresp", pio_timer_pkg::RESP_OKAY, rs)
  endtask

  initial
  begin
    {rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, ref_run, mon} = '0;
    {s_awaddr, s_araddr, s_wdata} = '0;
    stb_n = 1'b1;
    s_wstrb = 4'hf;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    rdc(pio_timer_pkg::OFF_CTRL, 32'h0);
    `CHK("tmr_out", 1'b1, tmr_out)
    wr(pio_timer_pkg::OFF_CTRL, 32'h22, pio_timer_pkg::RESP_OKAY);
    wr(pio_timer_pkg::OFF_P1, 32'ha5, pio_timer_pkg::RESP_OKAY);
    wr(pio_timer_pkg::OFF_P3, 32'h5, pio_timer_pkg::RESP_OKAY);
    rdc(pio_timer_pkg::OFF_P2, 32'h3c);
    rdc(pio_timer_pkg::OFF_P4, 32'h6);
    `CHK("out pins", {8'hff, 8'ha5, 8'h00, 3'h7, 3'h5}, {p1_oe, p1_out, p2_oe, p3_oe, p3_out})
    wr(pio_timer_pkg::OFF_CTRL, 32'h0d, pio_timer_pkg::RESP_OKAY);
    wr(pio_timer_pkg::OFF_P2, 32'h99, pio_timer_pkg::RESP_OKAY);
    rdc(pio_timer_pkg::OFF_STAT, 32'h0);
    `CHK("hs pins", {3'h3, 3'h3, 8'hff, 8'h99, 1'b0, 3'h2}, {p3_oe, p4_oe, p2_oe, p2_out, irq, p4_out})
    stb_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    stb_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdc(pio_timer_pkg::OFF_STAT, 32'h2);
    `CHK("p3 hs", 3'h3, p3_out)
    rdc(pio_timer_pkg::OFF_P1, 32'h81);
    `CHK("irq masked", 1'b0, irq)
    wr(pio_timer_pkg::OFF_MASK, 32'h2, pio_timer_pkg::RESP_OKAY);
    rdc(pio_timer_pkg::OFF_STAT, 32'h2);
    `CHK("irq on", {1'b1, 3'h0}, {irq, p3_out})
    wr(pio_timer_pkg::OFF_STAT, 32'h2, pio_timer_pkg::RESP_OKAY);
    rdc(pio_timer_pkg::OFF_STAT, 32'h0);
    `CHK("irq off", 1'b0, irq)
    wr(pio_timer_pkg::OFF_TLEN, 32'hffffffff, pio_timer_pkg::RESP_OKAY);
    rdc(pio_timer_pkg::OFF_TLEN, 32'h3fff);
    wr(pio_timer_pkg::OFF_TLEN, 32'h8, pio_timer_pkg::RESP_OKAY);
    ref_run <= 1'b1;
    // count of 8 ticks, 8 core cycles a tick; window ends before a third square fall
    for (int f = 0; f < 4; f++)
    begin
      {falls, lows} = '0;
      wr(pio_timer_pkg::OFF_CTRL, 32'h400 | 32'(f << 8), pio_timer_pkg::RESP_OKAY);
      mon <= 1'b1;
      rd(pio_timer_pkg::OFF_TCNT, v);
      repeat (24) @(posedge core_clk);
      rd(pio_timer_pkg::OFF_TCNT, t);
      `CHK("running", 2'b11, {v[14], t[14]})
      `CHK("count moves", 1'b1, v[13:0] != t[13:0])
      repeat (118) @(posedge core_clk);
      mon <= 1'b0;
      `CHK("falls", exp_falls[f], falls)
      // half of an 8-tick count low, or one tick low
      `CHK("low time", falls * (f < 2 ? 32 : 8), lows)
      wr(pio_timer_pkg::OFF_CTRL, 32'h800, pio_timer_pkg::RESP_OKAY);
    end
    rdc(pio_timer_pkg::OFF_STAT, 32'h1);
    wr(8'h40, 32'h1, pio_timer_pkg::RESP_SLVERR);
    rd(8'h40, v);
    `CHK("unmapped", {pio_timer_pkg::RESP_SLVERR, 32'h0}, {rs, v})
    report_and_stop();
  end
endmodule
